// [aif_pkg.sv]
// constants and carrier types for the ingress rule filter
package aif_pkg;
	localparam int NUM_ENTRIES = 16;
	localparam int IDX_W = 4;
	localparam int CNT_W = 11;
	localparam int ADDR_W = 12;
	localparam int FLD_W = 3;
	localparam int ENTRY_LSB = 5;
	localparam int FLD_LSB = 2;
	localparam int SPACE_BIT = 9;
	localparam logic [2:0] F_CTRL = 3'h0;
	localparam logic [2:0] F_DATA0 = 3'h1;
	localparam logic [2:0] F_DATA1 = 3'h2;
	localparam logic [2:0] F_ACTION = 3'h3;
	localparam logic [2:0] F_PROC = 3'h4;
	localparam logic [2:0] ST_LAST = 3'h0;
	localparam logic [2:0] ST_EVENTS = 3'h1;
	localparam logic [2:0] ST_CONFIG = 3'h2;
	localparam int CTRL_LAYER_LSB = 0;
	localparam int CTRL_ENB_LSB = 2;
	localparam int CTRL_SRC_BIT = 4;
	localparam int CTRL_EQ_BIT = 5;
	localparam int CTRL_WDOG_BIT = 6;
	localparam logic [31:0] CTRL_MASK = 32'h0000007f;
	localparam int PROC_MASK_LSB = 0;
	localparam int PROC_PTR_LSB = 16;
	localparam logic [31:0] PROC_MASK = 32'h000fffff;
	localparam int MAC_HI_LSB = 0;
	localparam int ETYPE_LSB = 16;
	localparam int LAST_IDX_LSB = 0;
	localparam int LAST_HIT_BIT = 8;
	localparam int CFG_EN_BIT = 0;
	localparam logic [1:0] LAYER_OFF = 2'h0;
	localparam logic [1:0] LAYER_L2 = 2'h1;
	localparam logic [1:0] LAYER_L3 = 2'h2;
	localparam logic [1:0] LAYER_L4 = 2'h3;
	localparam logic [1:0] FE_COUNT = 2'h0;
	localparam logic [1:0] FE_MAC = 2'h1;
	localparam logic [1:0] FE_TYPE = 2'h2;
	localparam logic [1:0] FE_BOTH = 2'h3;
	localparam logic [1:0] FE_IP_MASK = 2'h1;
	localparam logic [1:0] FE_IP_PAIR = 2'h2;
	localparam logic [1:0] FE_PROTO = 2'h0;
	localparam logic [1:0] FE_TCP = 2'h1;
	localparam logic [1:0] FE_UDP = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_PERIOD_NS = 25;
	localparam int WDOG_UNIT_NS = 1000;
	localparam int WDOG_UNIT_CYC = WDOG_UNIT_NS / CLK_PERIOD_NS;
	localparam int TICK_W = $clog2(WDOG_UNIT_CYC);
	typedef struct packed {
		logic [47:0] dmac;
		logic [47:0] smac;
		logic [15:0] ethertype;
		logic is_ipv4;
		logic [31:0] sip;
		logic [31:0] dip;
		logic [7:0] proto;
		logic is_tcp;
		logic is_udp;
		logic [15:0] sport;
		logic [15:0] dport;
		logic [8:0] tcp_flags;
	} aif_hdr_t;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] d0;
		logic [31:0] d1;
	} aif_rule_t;
	typedef struct packed {
		logic hit;
		logic [IDX_W-1:0] index;
		logic [31:0] action;
	} aif_dec_t;
endpackage

// [aif_match_eval.sv]
// one matching rule compared against a packet header
`timescale 1ns/1ps
`default_nettype none
module aif_match_eval (
	input wire aif_pkg::aif_rule_t rule,
	input wire aif_pkg::aif_hdr_t hdr,
	output logic hit,
	output logic cnt_hit
);
	import aif_pkg::*;
	logic [1:0] layer;
	logic [1:0] match_field_enable;
	logic eq;
	logic cmp;
	logic ok;
	logic mac_eq;
	logic type_eq;
	logic [31:0] ip;
	logic [15:0] port;
	always_comb begin
		layer = rule.ctrl[CTRL_LAYER_LSB +: 2];
		match_field_enable = rule.ctrl[CTRL_ENB_LSB +: 2];
		eq = rule.ctrl[CTRL_EQ_BIT];
		mac_eq = (rule.ctrl[CTRL_SRC_BIT] ? hdr.smac : hdr.dmac) ==
			{rule.d1[MAC_HI_LSB +: 16], rule.d0};
		type_eq = hdr.ethertype == rule.d1[ETYPE_LSB +: 16];
		ip = rule.ctrl[CTRL_SRC_BIT] ? hdr.sip : hdr.dip;
		port = rule.ctrl[CTRL_SRC_BIT] ? hdr.sport : hdr.dport;
		cmp = 1'b0;
		ok = 1'b0;
		cnt_hit = 1'b0;
		case (layer)
			LAYER_L2: begin
				ok = match_field_enable != FE_COUNT;
				cnt_hit = match_field_enable == FE_COUNT && mac_eq && type_eq;
				case (match_field_enable)
					FE_MAC: cmp = mac_eq;
					FE_TYPE: cmp = type_eq;
					default: cmp = mac_eq && type_eq;
				endcase
			end
			LAYER_L3: begin
				ok = hdr.is_ipv4 && (match_field_enable == FE_IP_MASK || match_field_enable == FE_IP_PAIR);
				if (match_field_enable == FE_IP_MASK) begin
					cmp = ((ip ^ rule.d0) & rule.d1) == 32'h0;
				end else begin
					cmp = hdr.sip == rule.d0 && hdr.dip == rule.d1;
				end
			end
			LAYER_L4: begin
				case (match_field_enable)
					FE_PROTO: begin
						ok = hdr.is_ipv4;
						cmp = hdr.proto == rule.d0[7:0];
					end
					FE_TCP: begin
						ok = hdr.is_tcp;
						cmp = port == rule.d0[15:0];
					end
					FE_UDP: begin
						ok = hdr.is_udp;
						cmp = port == rule.d0[15:0];
					end
					default: begin
						ok = hdr.is_tcp;
						cmp = ((hdr.tcp_flags ^ rule.d0[8:0]) & rule.d1[8:0]) == 9'h0;
					end
				endcase
			end
			default: ok = 1'b0;
		endcase
		hit = ok && (eq ? cmp : !cmp);
	end
endmodule
`default_nettype wire

// [aif_ingress_rule_filter.sv]
// ingress rule filter: table, evaluation pipeline, counters, AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module aif_ingress_rule_filter (
	input wire logic clk,
	input wire logic reset,
	input wire logic [aif_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [aif_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic hdr_valid,
	input wire aif_pkg::aif_hdr_t hdr,
	output logic dec_valid,
	output aif_pkg::aif_dec_t dec,
	output logic [aif_pkg::NUM_ENTRIES-1:0] count_event
);
	import aif_pkg::*;

	function automatic logic [IDX_W-1:0] ent(input logic [ADDR_W-1:0] a);
		return a[ENTRY_LSB +: IDX_W];
	endfunction
	function automatic logic [FLD_W-1:0] fld(input logic [ADDR_W-1:0] a);
		return a[FLD_LSB +: FLD_W];
	endfunction
	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		if (a[ADDR_W-1:SPACE_BIT+1] != '0) begin
			return 1'b0;
		end
		if (a[SPACE_BIT]) begin
			return ent(a) == '0 && fld(a) <= ST_CONFIG;
		end
		return fld(a) <= F_PROC;
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction
	function automatic logic is_count(input logic [31:0] c);
		return c[CTRL_LAYER_LSB +: 2] == LAYER_L2 &&
			c[CTRL_ENB_LSB +: 2] == FE_COUNT;
	endfunction

	logic [31:0] ctrl_q [NUM_ENTRIES];
	logic [31:0] d0_q [NUM_ENTRIES];
	logic [31:0] d1_q [NUM_ENTRIES];
	logic [31:0] act_q [NUM_ENTRIES];
	logic [31:0] proc_q [NUM_ENTRIES];
	logic [CNT_W-1:0] cnt_q [NUM_ENTRIES];
	logic filt_en_q;
	logic [NUM_ENTRIES-1:0] sticky_q;
	logic [NUM_ENTRIES-1:0] evt_q;
	logic last_hit_q;
	logic [IDX_W-1:0] last_idx_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic aw_have_q, w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_wr;
	logic [31:0] rd_word;
	aif_hdr_t hdr_q;
	logic hdr_v_q, match_v_q, dec_valid_q;
	aif_dec_t dec_q;
	logic [NUM_ENTRIES-1:0] m_hit, m_cnt, match_q, cnt_hit_q, act_req;
	logic [NUM_ENTRIES-1:0] sel;
	logic [IDX_W-1:0] ptr, sel_idx;
	logic sel_any;
	logic [TICK_W-1:0] tick_cnt_q;
	logic tick_q;
	logic [31:0] evt_clr;

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign dec_valid = dec_valid_q;
	assign dec = dec_q;
	assign count_event = evt_q;

	// write address and data, taken in either order
	assign do_wr = aw_have_q && w_have_q && !bvalid_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (awvalid && awready_q) begin
				aw_have_q <= 1'b1;
				awaddr_q <= awaddr;
				awready_q <= 1'b0;
			end
			if (wvalid && wready_q) begin
				w_have_q <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
				wready_q <= 1'b0;
			end
			if (do_wr) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// table and configuration writes
	always_ff @(posedge clk) begin
		if (reset) begin
			filt_en_q <= 1'b0;
			for (int i = 0; i < NUM_ENTRIES; i++) begin
				ctrl_q[i] <= '0;
				d0_q[i] <= '0;
				d1_q[i] <= '0;
				act_q[i] <= '0;
				proc_q[i] <= '0;
			end
		end else if (do_wr && addr_ok(awaddr_q)) begin
			if (awaddr_q[SPACE_BIT]) begin
				if (fld(awaddr_q) == ST_CONFIG && wstrb_q[0]) begin
					filt_en_q <= wdata_q[CFG_EN_BIT];
				end
			end else begin
				case (fld(awaddr_q))
					F_CTRL: ctrl_q[ent(awaddr_q)] <= merge(ctrl_q[ent(awaddr_q)],
						wdata_q, wstrb_q) & CTRL_MASK;
					F_DATA0: d0_q[ent(awaddr_q)] <= merge(d0_q[ent(awaddr_q)],
						wdata_q, wstrb_q);
					F_DATA1: d1_q[ent(awaddr_q)] <= merge(d1_q[ent(awaddr_q)],
						wdata_q, wstrb_q);
					F_ACTION: act_q[ent(awaddr_q)] <= merge(act_q[ent(awaddr_q)],
						wdata_q, wstrb_q);
					default: proc_q[ent(awaddr_q)] <= merge(proc_q[ent(awaddr_q)],
						wdata_q, wstrb_q) & PROC_MASK;
				endcase
			end
		end
	end

	// read decode
	always_comb begin
		rd_word = '0;
		if (addr_ok(araddr) && araddr[SPACE_BIT]) begin
			case (fld(araddr))
				ST_LAST: begin
					rd_word[LAST_IDX_LSB +: IDX_W] = last_idx_q;
					rd_word[LAST_HIT_BIT] = last_hit_q;
				end
				ST_EVENTS: rd_word[NUM_ENTRIES-1:0] = sticky_q;
				default: rd_word[CFG_EN_BIT] = filt_en_q;
			endcase
		end else if (addr_ok(araddr)) begin
			case (fld(araddr))
				F_CTRL: rd_word = ctrl_q[ent(araddr)];
				F_DATA0: rd_word = d0_q[ent(araddr)];
				F_DATA1: rd_word = d1_q[ent(araddr)];
				F_ACTION: rd_word = act_q[ent(araddr)];
				default: rd_word = proc_q[ent(araddr)];
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// header capture, then all sixteen matches in parallel
	always_ff @(posedge clk) begin
		if (reset) begin
			hdr_v_q <= 1'b0;
			hdr_q <= '0;
			match_v_q <= 1'b0;
			match_q <= '0;
			cnt_hit_q <= '0;
		end else begin
			hdr_v_q <= hdr_valid;
			if (hdr_valid) begin
				hdr_q <= hdr;
			end
			match_v_q <= hdr_v_q;
			match_q <= hdr_v_q ? m_hit : '0;
			cnt_hit_q <= hdr_v_q ? m_cnt : '0;
		end
	end

	for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_rule
		aif_match_eval u_eval (
			.rule({ctrl_q[g], d0_q[g], d1_q[g]}),
			.hdr(hdr_q),
			.hit(m_hit[g]),
			.cnt_hit(m_cnt[g])
		);
		a_wdog_restart: assert property (@(posedge clk)
			disable iff (reset) is_count(ctrl_q[g]) && filt_en_q &&
			ctrl_q[g][CTRL_WDOG_BIT] && cnt_hit_q[g] |=>
			cnt_q[g] == '0 && !evt_q[g])
			else $error("watchdog not restarted");
		a_evt_limit: assert property (@(posedge clk)
			disable iff (reset) evt_q[g] &&
			!$past(ctrl_q[g][CTRL_WDOG_BIT]) |->
			$past(cnt_hit_q[g]) && $past(cnt_q[g]) ==
			$past(act_q[g][CNT_W-1:0]) - 11'h1)
			else $error("event count wrong");
	end

	// processing entries: AND of selected matches, OR per action
	always_comb begin
		act_req = '0;
		sel = '0;
		ptr = '0;
		for (int j = 0; j < NUM_ENTRIES; j++) begin
			sel = proc_q[j][PROC_MASK_LSB +: NUM_ENTRIES];
			ptr = proc_q[j][PROC_PTR_LSB +: IDX_W];
			if (sel != '0 && (match_q & sel) == sel &&
				!is_count(ctrl_q[ptr])) begin
				act_req[ptr] = 1'b1;
			end
		end
		sel_idx = '0;
		sel_any = 1'b0;
		for (int k = NUM_ENTRIES - 1; k >= 0; k--) begin
			if (act_req[k]) begin
				sel_idx = IDX_W'(k);
				sel_any = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dec_valid_q <= 1'b0;
			dec_q <= '0;
			last_hit_q <= 1'b0;
			last_idx_q <= '0;
		end else begin
			dec_valid_q <= match_v_q;
			if (match_v_q) begin
				dec_q.hit <= filt_en_q && sel_any;
				dec_q.index <= sel_idx;
				dec_q.action <= act_q[sel_idx];
				last_hit_q <= filt_en_q && sel_any;
				last_idx_q <= sel_idx;
			end
		end
	end

	// time base for watchdog units
	always_ff @(posedge clk) begin
		if (reset) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_cnt_q == TICK_W'(WDOG_UNIT_CYC - 1);
			if (tick_cnt_q == TICK_W'(WDOG_UNIT_CYC - 1)) begin
				tick_cnt_q <= '0;
			end else begin
				tick_cnt_q <= tick_cnt_q + 1'b1;
			end
		end
	end

	// watchdog and event counters, limit held in action word
	always_ff @(posedge clk) begin
		if (reset) begin
			evt_q <= '0;
			for (int i = 0; i < NUM_ENTRIES; i++) begin
				cnt_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_ENTRIES; i++) begin
				evt_q[i] <= 1'b0;
				if (!filt_en_q || !is_count(ctrl_q[i]) ||
					act_q[i][CNT_W-1:0] == '0) begin
					cnt_q[i] <= '0;
				end else if (ctrl_q[i][CTRL_WDOG_BIT] && cnt_hit_q[i]) begin
					cnt_q[i] <= '0;
				end else if (ctrl_q[i][CTRL_WDOG_BIT] ? tick_q : cnt_hit_q[i]) begin
					if (cnt_q[i] == act_q[i][CNT_W-1:0] - 11'h1) begin
						cnt_q[i] <= '0;
						evt_q[i] <= 1'b1;
					end else begin
						cnt_q[i] <= cnt_q[i] + 11'h1;
					end
				end
			end
		end
	end

	// sticky event status, write one to clear, set wins
	assign evt_clr = (do_wr && addr_ok(awaddr_q) && awaddr_q[SPACE_BIT] &&
		fld(awaddr_q) == ST_EVENTS) ? merge('0, wdata_q, wstrb_q) : 32'h0;
	always_ff @(posedge clk) begin
		if (reset) begin
			sticky_q <= '0;
		end else begin
			sticky_q <= (sticky_q & ~evt_clr[NUM_ENTRIES-1:0]) | evt_q;
		end
	end

	sequence s_pkt_eval;
		hdr_v_q ##1 match_v_q;
	endsequence
	sequence s_rd_take;
		arvalid && arready_q;
	endsequence

	a_dec_latency: assert property (@(posedge clk) disable iff (reset)
		s_pkt_eval |=> dec_valid_q) else $error("decision late");
	a_dec_origin: assert property (@(posedge clk) disable iff (reset)
		dec_valid_q |-> $past(match_v_q, 1) && $past(hdr_v_q, 2))
		else $error("decision without packet");
	a_hit_enabled: assert property (@(posedge clk) disable iff (reset)
		dec_valid_q && dec_q.hit |-> $past(filt_en_q))
		else $error("hit while filter off");
	a_hit_priority: assert property (@(posedge clk) disable iff (reset)
		dec_valid_q && dec_q.hit |-> ($past(act_req) &
		((16'h1 << dec_q.index) - 16'h1)) == '0)
		else $error("lower action skipped");
	a_hit_request: assert property (@(posedge clk) disable iff (reset)
		dec_valid_q && dec_q.hit |-> (($past(act_req) >> dec_q.index) &
		16'h1) != '0) else $error("action not qualified");
	a_no_action: assert property (@(posedge clk) disable iff (reset)
		dec_valid_q && $past(filt_en_q) && $past(act_req) == '0 |->
		!dec_q.hit) else $error("action without match");
	a_sticky_set: assert property (@(posedge clk) disable iff (reset)
		evt_q != '0 |=> (sticky_q & $past(evt_q)) == $past(evt_q))
		else $error("event lost in status");
	a_evt_cause: assert property (@(posedge clk) disable iff (reset)
		evt_q != '0 |-> (evt_q & ~($past(cnt_hit_q) |
		{NUM_ENTRIES{$past(tick_q)}})) == '0) else $error("event uncaused");
	a_rd_answer: assert property (@(posedge clk) disable iff (reset)
		s_rd_take |=> rvalid_q && !arready_q) else $error("read not answered");
	a_wr_answer: assert property (@(posedge clk) disable iff (reset)
		do_wr |=> bvalid_q ##0 (!bready)[*1] |=> bvalid_q)
		else $error("write response dropped");
endmodule
`default_nettype wire

// [aif_pkt_src_model.sv]
// packet source model of the ingress path feeding the filter
`timescale 1ns/1ps
`default_nettype none
module aif_pkt_src_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic pkt_go,
	input wire aif_pkg::aif_hdr_t pkt_hdr,
	output logic hdr_valid,
	output aif_pkg::aif_hdr_t hdr
);
	import aif_pkg::*;
	// one header per cycle, scrambled between packets
	always_ff @(posedge clk) begin
		if (reset) begin
			hdr_valid <= 1'b0;
			hdr <= '0;
		end else begin
			hdr_valid <= pkt_go;
			hdr <= pkt_go ? pkt_hdr : ~hdr;
		end
	end
endmodule
`default_nettype wire

// [aif_ingress_rule_filter_test.sv]
// self-checking bench for the ingress rule filter
`timescale 1ns/1ps
`default_nettype none
module aif_ingress_rule_filter_test;
	import aif_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, act2, act5, r32;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, pkt_go = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, hdr_valid, dec_valid;
	logic [1:0] bresp, rresp;
	logic [15:0] count_event;
	logic [15:0] ev_seen = 16'h0;
	logic [15:0] seed = 16'h9450;
	logic [47:0] mac_a, mac_b;
	logic [33:0] e;
	aif_hdr_t hdr;
	aif_hdr_t pkt_hdr = '0;
	aif_hdr_t h3;
	aif_dec_t dec, x;
	logic [33:0] exp_bus[$];
	aif_dec_t exp_dec[$];
	int bad_count = 0, num_checks = 0, cyc = 0;

	aif_ingress_rule_filter i_aif_ingress_rule_filter (.clk(clk),
		.reset(reset), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.hdr_valid(hdr_valid), .hdr(hdr), .dec_valid(dec_valid),
		.dec(dec), .count_event(count_event));
	aif_pkt_src_model i_aif_pkt_src_model (.clk(clk), .reset(reset),
		.pkt_go(pkt_go), .pkt_hdr(pkt_hdr), .hdr_valid(hdr_valid),
		.hdr(hdr));

	always #12.5 clk = ~clk;

	task complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task chk(input string n, input logic [35:0] s, input logic [35:0] v);
		num_checks++;
		if (s !== v) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, v, s);
		end
	endtask

	function logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task rnd32(output logic [31:0] v);
		seed = lfsr(seed);
		v[15:0] = seed;
		seed = lfsr(seed);
		v[31:16] = seed;
	endtask

	function aif_hdr_t mk(input logic [47:0] m, input logic [15:0] t,
		input logic [15:0] p);
		mk = '0;
		mk.dmac = m;
		mk.smac = ~m;
		mk.ethertype = t;
		mk.is_ipv4 = 1'b1;
		mk.proto = 8'h06;
		mk.is_tcp = 1'b1;
		mk.dport = p;
		mk.sport = ~p;
	endfunction

	task wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r = RESP_OKAY);
		exp_bus.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (bvalid) bready <= 1'b1;
		end
		bready <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [33:0] v);
		exp_bus.push_back(v);
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1'b1;
		end
		rready <= 1'b0;
	endtask

	task pkt(input aif_hdr_t h, input logic ht, input logic [3:0] ix,
		input logic [31:0] a);
		exp_dec.push_back({ht, ix, a});
		pkt_go <= 1'b1;
		pkt_hdr <= h;
		@(posedge clk);
	endtask

	task drain();
		pkt_go <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		ev_seen <= ev_seen | count_event;
		if (bvalid && bready) begin
			e = exp_bus.pop_front();
			chk("bresp", {bresp, 32'h0}, e);
		end
		if (rvalid && rready) begin
			e = exp_bus.pop_front();
			chk("rdata", {rresp, rdata}, e);
		end
		if (dec_valid) begin
			x = exp_dec.pop_front();
			chk("hit", dec.hit, x.hit);
			if (x.hit) chk("dec", {dec.index, dec.action}, {x.index, x.action});
		end
		if (cyc == 5000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		rnd32(act2);
		rnd32(act5);
		rnd32(r32);
		mac_a = {act5[15:0], r32};
		mac_b = ~mac_a;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rd(12'h208, 34'h0);
		rd(12'h000, 34'h0);
		rd(12'h300, {RESP_SLVERR, 32'h0});
		wr(12'h300, 32'h1, RESP_SLVERR);
		wr(12'h000, 32'h25);
		wr(12'h004, mac_a[31:0]);
		wr(12'h008, {16'h0, mac_a[47:32]});
		wr(12'h020, 32'h29);
		wr(12'h028, 32'h08000000);
		wr(12'h040, 32'h27);
		wr(12'h044, 32'h1f90);
		wr(12'h04c, act2);
		wr(12'h0ac, act5);
		wr(12'h010, 32'h50001);
		wr(12'h030, 32'h20003);
		wr(12'h050, 32'h50004);
		wr(12'h080, 32'h21);
		wr(12'h084, mac_b[31:0]);
		wr(12'h088, {16'h88b5, mac_b[47:32]});
		wr(12'h08c, 32'h3);
		wr(12'h0e0, 32'h36);
		wr(12'h0e4, 32'h0a000000);
		wr(12'h0e8, 32'hff000000);
		wr(12'h0f0, 32'h10080);
		wr(12'h02c, r32);
		wr(12'h1e0, 32'hffffffff);
		rd(12'h1e0, {RESP_OKAY, 32'h7f});
		rd(12'h04c, {RESP_OKAY, act2});
		pkt(mk(mac_a, 16'h0800, 16'h0050), 1'b0, 4'h0, 32'h0);
		drain();
		wr(12'h208, 32'h1);
		pkt(mk(mac_a, 16'h0800, 16'h0050), 1'b1, 4'h2, act2);
		pkt(mk(mac_a, 16'h86dd, 16'h0050), 1'b1, 4'h5, act5);
		pkt(mk(mac_b, 16'h0800, 16'h0050), 1'b0, 4'h0, 32'h0);
		pkt(mk(mac_b, 16'h86dd, 16'h0050), 1'b0, 4'h0, 32'h0);
		pkt(mk(mac_b, 16'h86dd, 16'h1f90), 1'b1, 4'h5, act5);
		drain();
		rd(12'h200, {RESP_OKAY, 32'h105});
		h3 = mk(mac_b, 16'h0800, 16'h0050);
		h3.sip = 32'h0a0b0c0d;
		pkt(h3, 1'b1, 4'h1, r32);
		h3.sip = 32'h0b0b0c0d;
		pkt(h3, 1'b0, 4'h0, 32'h0);
		drain();
		repeat (3) pkt(mk(mac_b, 16'h88b5, 16'h0050), 1'b0, 4'h0, 32'h0);
		drain();
		chk("events", ev_seen, 36'h10);
		rd(12'h204, {RESP_OKAY, 32'h10});
		wr(12'h0c0, 32'h61);
		wr(12'h0c4, mac_a[31:0]);
		wr(12'h0c8, {16'h1234, mac_a[47:32]});
		wr(12'h0cc, 32'h2);
		repeat (130) @(posedge clk);
		rd(12'h204, {RESP_OKAY, 32'h50});
		pkt(mk(mac_a, 16'h1234, 16'h0050), 1'b1, 4'h5, act5);
		drain();
		wr(12'h204, 32'hffff);
		repeat (6) begin
			pkt(mk(mac_a, 16'h1234, 16'h0050), 1'b1, 4'h5, act5);
			drain();
			repeat (16) @(posedge clk);
		end
		rd(12'h204, 34'h0);
		wr(12'h0cc, 32'h0);
		wr(12'h204, 32'hffff);
		rd(12'h204, 34'h0);
		complete_run();
	end
endmodule
`default_nettype wire
